// ===== aux_flag_regs.svh
// Purpose: register offsets, character codes and field constants of the flag write command block
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only
`ifndef AUX_FLAG_REGS_SVH
`define AUX_FLAG_REGS_SVH

// ****************************************
// apb register offsets (byte addresses)
// ****************************************
`define REG_RXDATA 12'h000
`define REG_TXDATA 12'h004
`define REG_STATUS 12'h008
`define REG_FLAGS 12'h00c
`define STAT_TX_VALID 0
`define STAT_BUSY 1
`define RD_ZERO 32'h0000_0000

// ****************************************
// ascii codes of the frame
// ****************************************
`define CH_HASH 8'h23
`define CH_GT 8'h3e
`define CH_QM 8'h3f
`define CH_CR 8'h0d
`define CH_CODE0 8'h56
`define CH_CODE1_LC 8'h64
`define CH_CODE1_UC 8'h44
`define CH_ADDR_HI 8'h30
`define CH_ADDR_LO 8'h31

// ****************************************
// field lengths and selector layout
// ****************************************
`define CNT_ZERO 3'h0
`define CNT_STEP 3'h1
`define ADDR_LAST 3'h1
`define CODE_LAST 3'h1
`define SEL_LAST 3'h3
`define VAL_LAST 3'h7
`define SEL_ALL 16'h0000
`define SEL_ONE_LEAD 4'h1
`define SEL_MID_ZERO 8'h00
`define FLAGS_RST 16'h0000
`define VAL_RST 32'h0000_0000
`define REPLY_LAST 2'h3
`define REPLY_CNT_ZERO 3'h0
`define REPLY_CNT_FULL 3'h4
`define REPLY_CNT_STEP 3'h1
`define BYTE_ZERO 8'h00

`endif

// ===== aux_flag_pkg.sv
// Purpose: shared types of the flag write command block
// Assumes: nothing beyond the language
// Notes: constants live in aux_flag_regs.svh
package aux_flag_pkg;
	// one ascii character
	typedef logic [7:0] char_t;
	// parser states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CODE,
		ST_SEL,
		ST_VAL,
		ST_END,
		ST_DROP
	} parse_state_t;
endpackage

// ===== hex_char_decode.sv
// Purpose: turns one ascii character into a hex nibble
// Assumes: upper and lower case letters both count as hex
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module hex_char_decode (
	// character in
	input wire aux_flag_pkg::char_t ch,
	// nibble out
	output logic [3:0] nib,
	output logic ok
);
	import aux_flag_pkg::*;

	// digit, upper letter, lower letter
	always_comb begin
		nib = 4'h0;
		ok = 1'b0;
		if (ch >= 8'h30 && ch <= 8'h39) begin
			nib = ch[3:0];
			ok = 1'b1;
		end else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66)) begin
			nib = ch[3:0] + 4'h9;
			ok = 1'b1;
		end
	end
endmodule // hex_char_decode
`default_nettype wire

// ===== reply_sender.sv
// Purpose: holds a four character reply and hands it out one character per pop
// Assumes: a new load replaces any reply not yet read
// Notes: the head character comes straight from a flip-flop
`timescale 1ns/1ns
`default_nettype none
`include "aux_flag_regs.svh"
module reply_sender (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// load side
	input wire logic load,
	input wire aux_flag_pkg::char_t delim,
	// read side
	input wire logic pop,
	output aux_flag_pkg::char_t head,
	output logic valid
);
	import aux_flag_pkg::*;

	logic [31:0] buf_reg;
	logic [2:0] left_reg;

	// reply characters, oldest in the top byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_reg <= `VAL_RST;
		end else if (load) begin
			buf_reg <= {delim, `CH_ADDR_HI, `CH_ADDR_LO, `CH_CR};
		end else if (pop && valid) begin
			buf_reg <= {buf_reg[23:0], `BYTE_ZERO};
		end
	end

	// characters still to be read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg <= `REPLY_CNT_ZERO;
		end else if (load) begin
			left_reg <= `REPLY_CNT_FULL;
		end else if (pop && valid) begin
			left_reg <= left_reg - `REPLY_CNT_STEP;
		end
	end

	assign head = buf_reg[31:24];
	assign valid = (left_reg != `REPLY_CNT_ZERO);
endmodule // reply_sender
`default_nettype wire

// ===== aux_flag_write_command.sv
// Purpose: parses the ascii flag write command and updates sixteen auxiliary logic flags
// Assumes: software feeds command characters over apb and reads reply characters back
// Notes: zero wait state apb slave; unmapped addresses answer pslverr
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "aux_flag_regs.svh"
module aux_flag_write_command (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flag outputs
	output logic [15:0] auxiliary_logic_flags
);
	import aux_flag_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	parse_state_t state_reg;
	parse_state_t state_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [15:0] sel_reg;
	logic [31:0] val_reg;
	logic [15:0] flags_reg;
	char_t rx_char;
	logic rx_stb;
	logic [3:0] hex_nib;
	logic hex_ok;
	logic frame_done;
	logic sel_all;
	logic sel_one;
	logic exec_all;
	logic exec_one;
	logic exec_bad;
	logic reply_load;
	char_t reply_delim;
	char_t tx_char;
	logic tx_valid;
	logic tx_pop;
	logic setup_ph;
	logic access_ph;
	logic addr_hit;
	// reset level of every flag, one bit per flop
	localparam logic [15:0] flags_rst = `FLAGS_RST;

	// ****************************************
	// apb slave
	// ****************************************
	// phases of a transfer
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign pready = 1'b1;

	// decode of the mapped words
	always_comb begin
		case (paddr)
			`REG_RXDATA: addr_hit = 1'b1;
			`REG_TXDATA: addr_hit = 1'b1;
			`REG_STATUS: addr_hit = 1'b1;
			`REG_FLAGS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RD_ZERO;
		end else if (setup_ph && !pwrite) begin
			case (paddr)
				`REG_TXDATA: prdata <= {24'h00_0000, tx_char};
				`REG_STATUS: prdata <= {30'h0000_0000, state_reg != ST_IDLE, tx_valid};
				`REG_FLAGS: prdata <= {16'h0000, flags_reg};
				default: prdata <= `RD_ZERO;
			endcase
		end
	end

	// error answer captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			pslverr <= !addr_hit;
		end
	end

	// character strobes
	assign rx_stb = access_ph && pwrite && (paddr == `REG_RXDATA);
	assign rx_char = pwdata[7:0];
	assign tx_pop = access_ph && !pwrite && (paddr == `REG_TXDATA);

	// ****************************************
	// character decode
	// ****************************************
	hex_char_decode u_hex (
		.ch(rx_char),
		.nib(hex_nib),
		.ok(hex_ok)
	);

	// ****************************************
	// parser
	// ****************************************
	// next state of the frame parser
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (rx_stb) begin
			cnt_next = cnt_reg + `CNT_STEP;
			// a hash always opens a new frame
			if (rx_char == `CH_HASH) begin
				state_next = ST_ADDR;
				cnt_next = `CNT_ZERO;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						state_next = ST_IDLE;
					end
					ST_ADDR: begin
						if (cnt_reg == `CNT_ZERO && rx_char != `CH_ADDR_HI) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `ADDR_LAST && rx_char != `CH_ADDR_LO) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `ADDR_LAST) begin
							state_next = ST_CODE;
							cnt_next = `CNT_ZERO;
						end
					end
					ST_CODE: begin
						if (cnt_reg == `CNT_ZERO && rx_char != `CH_CODE0) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `CODE_LAST && rx_char != `CH_CODE1_LC
								&& rx_char != `CH_CODE1_UC) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `CODE_LAST) begin
							state_next = ST_SEL;
							cnt_next = `CNT_ZERO;
						end
					end
					ST_SEL: begin
						// non hex selector is a syntax error
						if (!hex_ok) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `SEL_LAST) begin
							state_next = ST_VAL;
							cnt_next = `CNT_ZERO;
						end
					end
					ST_VAL: begin
						if (!hex_ok) begin
							state_next = ST_DROP;
						end else if (cnt_reg == `VAL_LAST) begin
							state_next = ST_END;
							cnt_next = `CNT_ZERO;
						end
					end
					ST_END: begin
						// frame must close with carriage return
						state_next = (rx_char == `CH_CR) ? ST_IDLE : ST_DROP;
						cnt_next = `CNT_ZERO;
					end
					ST_DROP: begin
						if (rx_char == `CH_CR) begin
							state_next = ST_IDLE;
						end
						cnt_next = `CNT_ZERO;
					end
					default: begin
						state_next = ST_IDLE;
						cnt_next = `CNT_ZERO;
					end
				endcase
			end
		end
	end

	// parser state and field counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= `CNT_ZERO;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// selector nibbles, first character on top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= `SEL_ALL;
		end else if (rx_stb && state_reg == ST_SEL && hex_ok) begin
			sel_reg <= {sel_reg[11:0], hex_nib};
		end
	end

	// each value character shifts in four bits; the last four characters fill the flag bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			val_reg <= `VAL_RST;
		end else if (rx_stb && state_reg == ST_VAL && hex_ok) begin
			val_reg <= {val_reg[27:0], hex_nib};
		end
	end

	// ****************************************
	// execution
	// ****************************************
	// a command acts only on its closing carriage return
	assign frame_done = rx_stb && state_reg == ST_END && rx_char == `CH_CR;
	assign sel_all = (sel_reg == `SEL_ALL);
	// single flag mode, number in the last character
	assign sel_one = (sel_reg[15:12] == `SEL_ONE_LEAD) && (sel_reg[11:4] == `SEL_MID_ZERO);
	assign exec_all = frame_done && sel_all;
	assign exec_one = frame_done && sel_one;
	// any other selector is an invalid command
	assign exec_bad = frame_done && !sel_all && !sel_one;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flags_reg[g] <= flags_rst[g];
				end else if (exec_all) begin
					// bit i of the value drives flag i
					flags_reg[g] <= val_reg[g];
				end else if (exec_one && sel_reg[3:0] == 4'(g)) begin
					// value lsb drives the named flag
					flags_reg[g] <= val_reg[0];
				end
			end
		end
	endgenerate

	assign auxiliary_logic_flags = flags_reg;

	// ****************************************
	// reply
	// ****************************************
	// greater-than for valid, question mark for invalid
	assign reply_load = exec_all || exec_one || exec_bad;
	assign reply_delim = exec_bad ? `CH_QM : `CH_GT;

	// reply carries our own address and a carriage return
	reply_sender u_reply (
		.pclk(pclk),
		.presetn(presetn),
		.load(reply_load),
		.delim(reply_delim),
		.pop(tx_pop),
		.head(tx_char),
		.valid(tx_valid)
	);

	// ****************************************
	// checks
	// ****************************************
	AST_ADDR_FOREIGN: assert property (@(posedge pclk) disable iff (!presetn)
		rx_stb && state_reg == ST_ADDR && cnt_reg == `CNT_ZERO && rx_char != `CH_ADDR_HI
			&& rx_char != `CH_HASH |=> state_reg == ST_DROP)
		else $error("foreign address not dropped");

	AST_CODE_BAD: assert property (@(posedge pclk) disable iff (!presetn)
		rx_stb && state_reg == ST_CODE && cnt_reg == `CNT_ZERO && rx_char != `CH_CODE0
			&& rx_char != `CH_HASH |=> state_reg == ST_DROP)
		else $error("bad access code not dropped");

	AST_ALL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		exec_all |=> flags_reg == $past(val_reg[15:0]))
		else $error("all flags write wrong");

	AST_ONE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		exec_one |=> flags_reg[$past(sel_reg[3:0])] == $past(val_reg[0]))
		else $error("single flag write wrong");

	AST_ONE_OTHERS: assert property (@(posedge pclk) disable iff (!presetn)
		exec_one |=> ((flags_reg ^ $past(flags_reg)) & ~(16'h0001 << $past(sel_reg[3:0]))) == 16'h0000)
		else $error("other flags disturbed");

	AST_VAL_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
		rx_stb && state_reg == ST_VAL && hex_ok && rx_char != `CH_HASH
			|=> val_reg[3:0] == $past(hex_nib) && val_reg[31:4] == $past(val_reg[27:0]))
		else $error("value nibble not stored");

	AST_CR_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
		reply_load |-> rx_stb && rx_char == `CH_CR && state_reg == ST_END)
		else $error("command acted without carriage return");

	AST_GOOD_REPLY: assert property (@(posedge pclk) disable iff (!presetn)
		(exec_all || exec_one) |=> tx_valid && tx_char == `CH_GT)
		else $error("valid reply missing");

	AST_BAD_REPLY: assert property (@(posedge pclk) disable iff (!presetn)
		exec_bad |=> $stable(flags_reg) && tx_valid && tx_char == `CH_QM)
		else $error("invalid reply or flag change wrong");

	AST_DROP_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_DROP && !tx_valid |=> !tx_valid)
		else $error("reply sent on dropped frame");

	AST_REPLY_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
		tx_pop && tx_valid && !reply_load && (tx_char == `CH_GT || tx_char == `CH_QM)
			|=> tx_char == `CH_ADDR_HI)
		else $error("reply address wrong");
endmodule // aux_flag_write_command
`default_nettype wire

// ===== cmd_host.sv
// Purpose: host model that frames ascii commands and moves words over apb
// Assumes: slave answers within the bounded wait
// Notes: tasks are called by the bench; stalls counts waits that ran out
`timescale 1ns/1ns
`default_nettype none
`include "aux_flag_regs.svh"
module cmd_host (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int stalls = 0;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// one transfer, request held until pready is sampled high or 64 waits run out
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 64) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 64) stalls++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data does not linger
		@(posedge pclk);
	endtask
	// one character into the receive register
	task automatic send_char(input logic [7:0] c);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, `REG_RXDATA, {24'h00_0000, c}, rd, err);
	endtask
	// hash, address, code, selector, value, cr
	task automatic send_cmd(input string aa, input string code, input string sel, input string val, input bit cr);
		string s;
		s = {"#", aa, code, sel, val};
		for (int i = 0; i < s.len(); i++) send_char(s[i]);
		if (cr) send_char(`CH_CR);
	endtask
endmodule // cmd_host
`default_nettype wire

// ===== aux_flag_write_command_bench.sv
// Purpose: self-checking bench of the flag write command block
// Assumes: zero wait apb slave, host model drives the bus
// Notes: expectations come from the command rules only
`timescale 1ns/1ns
`default_nettype none
`include "aux_flag_regs.svh"
module aux_flag_write_command_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] flags;
	logic [15:0] exp;
	int n_errors = 0;
	int n_compared = 0;
	string bad_aa[5] = '{"02", "10", "01", "01", "01"};
	string bad_cd[5] = '{"Vd", "Vd", "xd", "Vx", "Vd"};
	string bad_vl[5] = '{"0000FFFF", "0000FFFF", "0000FFFF", "0000FFFF", "0000G0FF"};
	// ****************************************
	// clock, host and design
	// ****************************************
	always #4 pclk = ~pclk;
	cmd_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	aux_flag_write_command DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .auxiliary_logic_flags(flags));
	// ****************************************
	// checking tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			$display("FAIL %s expected %h seen %h", what, want, seen);
			n_errors++;
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
		host.xfer(1'b0, a, 32'h0000_0000, d, e);
	endtask
	task automatic check_flags(input logic [15:0] want);
		logic [31:0] d;
		logic e;
		rd(`REG_FLAGS, d, e);
		check("flag register", d, {16'h0000, want});
		check("flag pins", {16'h0000, flags}, {16'h0000, want});
	endtask
	// reply drained char by char, then empty
	task automatic expect_reply(input logic [7:0] delim);
		logic [31:0] d;
		logic e;
		rd(`REG_STATUS, d, e);
		check("reply ready", d & 32'h1, 32'h1);
		rd(`REG_TXDATA, d, e);
		check("reply delimiter", d, {24'h0, delim});
		rd(`REG_TXDATA, d, e);
		check("reply addr hi", d, {24'h0, `CH_ADDR_HI});
		rd(`REG_TXDATA, d, e);
		check("reply addr lo", d, {24'h0, `CH_ADDR_LO});
		rd(`REG_TXDATA, d, e);
		check("reply end", d, {24'h0, `CH_CR});
		rd(`REG_STATUS, d, e);
		check("reply drained", d & 32'h1, 32'h0);
	endtask
	task automatic give_verdict();
		n_errors += host.stalls;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// a stalled transfer ends the run at once
	always @(posedge pclk) begin
		if (host.stalls != 0) begin
			give_verdict();
		end
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic e;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check_flags(16'h0000);
		$display("test reset done");
		host.send_cmd("01", "Vd", "0000", "ABCD1234", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'h1234);
		host.send_cmd("01", "VD", "0000", "0000FFFF", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'hffff);
		host.send_cmd("01", "Vd", "0000", "00000000", 1'b1);
		expect_reply(`CH_GT);
		$display("test all flags done");
		exp = 16'h0000;
		for (int n = 0; n < 16; n++) begin
			host.send_cmd("01", "Vd", $sformatf("100%h", n[3:0]), "00000001", 1'b1);
			exp = exp | (16'h0001 << n);
			expect_reply(`CH_GT);
			check_flags(exp);
		end
		host.send_cmd("01", "Vd", "100E", "00000000", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'hbfff);
		host.send_cmd("01", "Vd", "1000", "0000000E", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'hbffe);
		host.send_cmd("01", "Vd", "100E", "0000000F", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'hfffe);
		$display("test single flag done");
		host.send_cmd("01", "Vd", "2000", "00000000", 1'b1);
		expect_reply(`CH_QM);
		check_flags(16'hfffe);
		host.send_cmd("01", "Vd", "1010", "00000001", 1'b1);
		expect_reply(`CH_QM);
		check_flags(16'hfffe);
		$display("test invalid done");
		for (int k = 0; k < 5; k++) begin
			host.send_cmd(bad_aa[k], bad_cd[k], "0000", bad_vl[k], 1'b1);
			rd(`REG_STATUS, d, e);
			check("silent frame", d & 32'h1, 32'h0);
			check_flags(16'hfffe);
		end
		$display("test silent done");
		host.send_cmd("01", "Vd", "0000", "00000000", 1'b0);
		rd(`REG_STATUS, d, e);
		check("mid frame", d & 32'h2, 32'h2);
		host.send_cmd("01", "Vd", "0000", "00005A5A", 1'b1);
		expect_reply(`CH_GT);
		check_flags(16'h5a5a);
		$display("test restart done");
		host.xfer(1'b1, `REG_FLAGS, 32'h0000_0000, d, e);
		check_flags(16'h5a5a);
		rd(12'h010, d, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", d, `RD_ZERO);
		check("bus ready", {31'h0, pready}, 32'h1);
		$display("test bus done");
		give_verdict();
	end
endmodule // aux_flag_write_command_bench
`default_nettype wire
